// ==== design/srpc_main.sv ====
/*
 Sequence replay controller: walks the step table, replays segments from
 the external sample memory and feeds the converter path.
 Assumes sample memory answers in the same clock an address is presented,
 and that all inputs are synchronous to the sample clock.
*/
//
// Contract
// - Sequence table holds 1 to 4096 programmable steps.
// - Step entries may be rewritten during replay; new contents used next.
// - Waveform memory splits into 2 to 64Ki programmable segments.
// - Segment samples may be replaced by the host during replay.
// - Segment length capped: memory / channels / pow2-rounded segment count.
// - Per-step loop count 1 to 1Mi-1; segment replayed that often.
// - Next command replays loop count then jumps to designated step.
// - Until-trigger command repeats until trigger; end command stops sequence.
// - Index of the step being replayed is readable at any time.
// - Sequence changes and trigger loops are not synchronised across cards.
// - External trigger delayed 22 sample clocks before becoming internal.
`timescale 1ns/100ps
module srpc_main
   import srpc_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic start,
   input wire logic stop,
   input wire logic [12:0] step_count,
   input wire logic [16:0] segment_count,
   input wire logic [3:0] active_channels,
   input wire logic step_wr_en,
   input wire logic [11:0] step_wr_index,
   input wire logic [15:0] step_wr_segment,
   input wire logic [11:0] step_wr_next,
   input wire logic [19:0] step_wr_loops,
   input wire logic [1:0] step_wr_command,
   input wire logic seg_wr_en,
   input wire logic [15:0] seg_wr_index,
   input wire logic [29:0] seg_wr_length,
   input wire logic ext_trigger,
   input wire logic [15:0] sample_data,
   output logic [28:0] sample_addr,
   output logic sample_read,
   output logic [15:0] dac_data,
   output logic dac_valid,
   output logic [11:0] current_step,
   output logic running,
   output logic done
);
   typedef struct packed {
      srpc_state_e state;
      logic [11:0] step;
      logic [1:0] command;
      logic [11:0] next_step;
      logic [19:0] loops;
      logic [19:0] iter;
      logic [28:0] base;
      logic [29:0] length;
      logic [29:0] offset;
      logic trig_seen;
      logic trig_last;
      logic [28:0] addr;
      logic valid;
      logic [15:0] data;
      logic data_valid;
   } srpc_ctl_s;

   srpc_ctl_s cur;
   srpc_ctl_s next_cur;

   // Tables live in plain arrays; host writes land at any time
   srpc_step_s step_mem [SRPC_STEP_DEPTH];
   logic [29:0] seg_len_mem [SRPC_SEG_DEPTH];

   logic trig_delayed;
   logic trig_event;
   logic [4:0] chan_log;
   logic [4:0] seg_log;
   logic [4:0] seg_shift;
   logic [29:0] max_len;
   logic [45:0] base_wide;
   logic [29:0] raw_len;
   logic [29:0] eff_len;
   logic [12:0] next_idx_wide;
   srpc_step_s entry;

   // Ceiling log2 of the programmed segment count
   function automatic logic [4:0] srpc_clog2(input logic [16:0] n);
      logic [4:0] r;
      r = 5'h0;
      for (int i = 0; i < 17; i++) begin
         if ((17'h1 << i) < n) begin
            r = 5'(i + 1);
         end
      end
      return r;
   endfunction

   // Pipeline delay keeps trigger timing aligned with the output path
   srpc_trig_delay #(
      .DEPTH(SRPC_TRIG_DELAY)
   ) u_trig_delay (
      .clock(clock),
      .reset_n(reset_n),
      .trig_in(ext_trigger),
      .trig_out(trig_delayed)
   );

   // Rising edge of the delayed trigger; local to this card only
   assign trig_event = trig_delayed & ~cur.trig_last;

   // Table writes accepted while replay runs
   always_ff @(posedge clock) begin
      if (step_wr_en) begin
         step_mem[step_wr_index] <= '{segment: step_wr_segment,
            next_step: step_wr_next, loops: step_wr_loops,
            command: step_wr_command};
      end
      if (seg_wr_en) begin
         seg_len_mem[seg_wr_index] <= seg_wr_length;
      end
   end

   // Segment size limit and placement from channel and segment counts
   always_comb begin
      case (active_channels)
         4'h1: chan_log = 5'h0;
         4'h2: chan_log = 5'h1;
         4'h4: chan_log = 5'h2;
         4'h8: chan_log = 5'h3;
         default: chan_log = 5'h3;
      endcase
      seg_log = srpc_clog2((segment_count < 17'h2) ? 17'h2 : segment_count);
      seg_shift = 5'(SRPC_MEM_LOG2) - chan_log - seg_log;
      max_len = 30'h1 << seg_shift;
      entry = step_mem[cur.step];
      base_wide = {30'h0, entry.segment} << seg_shift;
      raw_len = seg_len_mem[entry.segment];
      // Short entries are padded so a bad length cannot stall the walk
      eff_len = (raw_len > max_len) ? max_len : raw_len;
      if (eff_len < SRPC_MIN_SEG_LEN) begin
         eff_len = (max_len < SRPC_MIN_SEG_LEN) ? max_len : SRPC_MIN_SEG_LEN;
      end
      // Next index outside the programmed table falls back to step 0
      next_idx_wide = {1'b0, cur.next_step};
   end

   // Replay sequencer
   always_comb begin
      next_cur = cur;
      next_cur.trig_last = trig_delayed;
      next_cur.valid = 1'b0;
      // Memory answers in the same clock the address is presented; register it toward the DAC
      next_cur.data_valid = cur.valid;
      if (cur.valid) begin
         next_cur.data = sample_data;
      end
      // A trigger seen during an until-trigger step is held until used
      if (trig_event) begin
         next_cur.trig_seen = 1'b1;
      end
      case (cur.state)
         SRPC_IDLE, SRPC_DONE: begin
            if (start) begin
               next_cur.state = SRPC_FETCH;
               next_cur.step = SRPC_STEP_RST;
            end
         end
         SRPC_FETCH: begin
            // Contents read now, so rewrites take effect on next execution
            next_cur.command = entry.command;
            next_cur.next_step = entry.next_step;
            next_cur.loops = (entry.loops == 20'h0) ? 20'h1 : entry.loops;
            next_cur.iter = 20'h0;
            next_cur.base = base_wide[28:0];
            next_cur.length = eff_len;
            next_cur.offset = 30'h0;
            next_cur.trig_seen = trig_event;
            next_cur.state = SRPC_PLAY;
         end
         SRPC_PLAY: begin
            next_cur.addr = cur.base + cur.offset[28:0];
            next_cur.valid = 1'b1;
            next_cur.offset = cur.offset + 30'h1;
            // Decisions only at the last sample of an iteration
            if (cur.offset == cur.length - 30'h1) begin
               next_cur.offset = 30'h0;
               next_cur.iter = cur.iter + 20'h1;
               if (cur.command == SRPC_CMD_UNTIL_TRIG) begin
                  if (cur.trig_seen || trig_event) begin
                     next_cur.state = SRPC_FETCH;
                     next_cur.step = (next_idx_wide < step_count) ?
                        cur.next_step : SRPC_STEP_RST;
                  end
               end else if (cur.iter + 20'h1 >= cur.loops) begin
                  if (cur.command == SRPC_CMD_END) begin
                     next_cur.state = SRPC_DONE;
                  end else begin
                     next_cur.state = SRPC_FETCH;
                     next_cur.step = (next_idx_wide < step_count) ?
                        cur.next_step : SRPC_STEP_RST;
                  end
               end
            end
         end
         default: begin
            next_cur.state = SRPC_IDLE;
         end
      endcase
      // Stop aborts at once; no cross-card coordination applies
      if (stop) begin
         next_cur.state = SRPC_IDLE;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cur <= '{state: SRPC_IDLE, step: SRPC_STEP_RST, command: 2'h0,
            next_step: SRPC_STEP_RST, loops: 20'h0, iter: 20'h0,
            base: SRPC_ADDR_RST, length: 30'h0, offset: 30'h0,
            trig_seen: 1'b0, trig_last: 1'b0, addr: SRPC_ADDR_RST,
            valid: 1'b0, data: SRPC_DATA_RST, data_valid: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   assign sample_addr = cur.addr;
   assign sample_read = cur.valid;
   assign dac_data = cur.data;
   assign dac_valid = cur.data_valid;
   assign current_step = cur.step;
   assign running = (cur.state == SRPC_FETCH) || (cur.state == SRPC_PLAY);
   assign done = (cur.state == SRPC_DONE);
endmodule // srpc_main

// ==== design/srpc_pkg.sv ====
/*
 Shared constants and types for the sequence replay controller.
 Assumes one sampling clock for every user of these definitions.
*/
package srpc_pkg;
   // Sample memory: 512 Mi samples, addressed by sample
   localparam int SRPC_MEM_LOG2 = 29;
   localparam int SRPC_ADDR_W = 29;
   localparam int SRPC_SAMPLE_W = 16;
   // Sequence table: 1 up to 4096 steps
   localparam int SRPC_STEP_W = 12;
   localparam int SRPC_STEP_CNT_W = 13;
   localparam int SRPC_STEP_DEPTH = 4096;
   // Segments: 2 up to 64Ki
   localparam int SRPC_SEG_W = 16;
   localparam int SRPC_SEG_CNT_W = 17;
   localparam int SRPC_SEG_DEPTH = 65536;
   localparam int SRPC_LEN_W = 30;
   localparam logic [29:0] SRPC_MIN_SEG_LEN = 30'h20;
   localparam int SRPC_SEG_GRAN = 8;
   // Loops: 1 to 1Mi-1
   localparam int SRPC_LOOP_W = 20;
   // External trigger pipeline delay in sample clocks
   localparam int SRPC_TRIG_DELAY = 22;
   // Reset values
   localparam logic [11:0] SRPC_STEP_RST = 12'h000;
   localparam logic [28:0] SRPC_ADDR_RST = 29'h0;
   localparam logic [15:0] SRPC_DATA_RST = 16'h0;

   typedef enum logic [1:0] {
      SRPC_CMD_NEXT = 2'h0,
      SRPC_CMD_UNTIL_TRIG = 2'h1,
      SRPC_CMD_END = 2'h2
   } srpc_cmd_e;

   typedef enum logic [3:0] {
      SRPC_IDLE = 4'h1,
      SRPC_FETCH = 4'h2,
      SRPC_PLAY = 4'h4,
      SRPC_DONE = 4'h8
   } srpc_state_e;

   typedef struct packed {
      logic [15:0] segment;
      logic [11:0] next_step;
      logic [19:0] loops;
      logic [1:0] command;
   } srpc_step_s;
endpackage

// ==== design/srpc_trig_delay.sv ====
/*
 Fixed pipeline delay for the external trigger pulse.
 Assumes the trigger input is already synchronous to the sample clock.
*/
`timescale 1ns/100ps
module srpc_trig_delay
   import srpc_pkg::*;
#(
   parameter int DEPTH = SRPC_TRIG_DELAY
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic trig_in,
   output logic trig_out
);
   typedef struct packed {
      logic [DEPTH-1:0] pipe;
   } srpc_dly_s;

   srpc_dly_s cur;
   srpc_dly_s next_cur;

   // Shift one stage per sample clock
   always_comb begin
      next_cur = cur;
      next_cur.pipe = {cur.pipe[DEPTH-2:0], trig_in};
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign trig_out = cur.pipe[DEPTH-1];
endmodule // srpc_trig_delay

// ==== testbench/srpc_main_assertions.sv ====
/*
 Port checker for the sequence replay controller.
 Assumes one sample clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module srpc_main_assertions (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic start,
   input wire logic stop,
   input wire logic sample_read,
   input wire logic [15:0] sample_data,
   input wire logic [15:0] dac_data,
   input wire logic dac_valid,
   input wire logic running,
   input wire logic done
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic [31:0] run_cnt;
   // Length of the unbroken read run, for the no-truncation check
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         run_cnt <= 32'h0;
      else
         run_cnt <= sample_read ? run_cnt + 32'h1 : 32'h0;
   end
   property p_launch;
      !running && start && !stop |=> running ##1 running ##1 sample_read;
   endproperty
   property p_follow;
      sample_read |=> dac_valid;
   endproperty
   property p_quiet;
      !sample_read |=> !dac_valid;
   endproperty
   property p_data;
      dac_valid |-> dac_data == $past(sample_data);
   endproperty
   property p_excl;
      !(running && done);
   endproperty
   property p_stop;
      stop |=> !running && !done;
   endproperty
   property p_hold;
      done && !start && !stop |=> done;
   endproperty
   property p_end;
      $rose(done) |-> $past(running);
   endproperty
   // Stop may cut a run short, so runs near a stop are exempt
   property p_run;
      $fell(sample_read) && !$past(stop, 1) && !$past(stop, 2)
         |-> run_cnt >= 32 && run_cnt[2:0] == 3'h0;
   endproperty
   a_launch: assert property (p_launch)
      else $error("launch timing wrong");
   a_follow: assert property (p_follow)
      else $error("read not followed by converter word");
   a_quiet: assert property (p_quiet)
      else $error("converter word without read");
   a_data: assert property (p_data)
      else $error("converter word differs from memory word");
   a_excl: assert property (p_excl)
      else $error("running and done together");
   a_stop: assert property (p_stop)
      else $error("stop not obeyed");
   a_hold: assert property (p_hold)
      else $error("done dropped on its own");
   a_end: assert property (p_end)
      else $error("done without replay");
   a_run: assert property (p_run)
      else $error("read run truncated");
   c_done: cover property ($rose(done));
   c_stop: cover property (stop && running);
   c_gap: cover property ($fell(sample_read) && running);
endmodule // srpc_main_assertions
bind srpc_main srpc_main_assertions i_chk (.clock(clock), .reset_n(reset_n),
   .start(start), .stop(stop), .sample_read(sample_read),
   .sample_data(sample_data), .dac_data(dac_data), .dac_valid(dac_valid),
   .running(running), .done(done));

// ==== testbench/srpc_main_tb_top.sv ====
/*
 Testbench for the sequence replay controller: walk, trigger loop, stop.
 Assumes srpc_mem_model stands in for the external sample memory.
*/
`timescale 1ns/100ps
module srpc_main_tb_top
   import srpc_pkg::*;
;
   logic clock = 0, reset_n = 0, start = 0, stop = 0, ext_trigger = 0;
   logic step_wr_en = 0, seg_wr_en = 0, sample_read, dac_valid, running;
   logic done, seen = 0;
   logic [12:0] step_count = 13'h1000;
   logic [16:0] segment_count = 17'h2;
   logic [3:0] active_channels = 4'h1;
   logic [11:0] step_wr_index = '0, step_wr_next = '0, current_step;
   logic [15:0] step_wr_segment = '0, seg_wr_index = '0, pattern = '0;
   logic [15:0] sample_data, dac_data, last_pat = '0;
   logic [19:0] step_wr_loops = '0;
   logic [1:0] step_wr_command = '0;
   logic [29:0] seg_wr_length = '0;
   logic [28:0] sample_addr, last_addr = '0, first_addr = '0;
   int fail_count = 0, compares = 0, cyc = 0, reads = 0;
   logic [15:0] exp_word;
   // Memory word of the last read, with the overlay then in force
   assign exp_word = last_addr[15:0] ^ last_addr[28:13] ^ last_pat;
   initial forever #2.5 clock = ~clock;
   srpc_main i_dut (.clock(clock), .reset_n(reset_n), .start(start),
      .stop(stop), .step_count(step_count), .segment_count(segment_count),
      .active_channels(active_channels), .step_wr_en(step_wr_en),
      .step_wr_index(step_wr_index), .step_wr_segment(step_wr_segment),
      .step_wr_next(step_wr_next), .step_wr_loops(step_wr_loops),
      .step_wr_command(step_wr_command), .seg_wr_en(seg_wr_en),
      .seg_wr_index(seg_wr_index), .seg_wr_length(seg_wr_length),
      .ext_trigger(ext_trigger), .sample_data(sample_data),
      .sample_addr(sample_addr), .sample_read(sample_read),
      .dac_data(dac_data), .dac_valid(dac_valid),
      .current_step(current_step), .running(running), .done(done));
   srpc_mem_model i_mem (.sample_addr(sample_addr),
      .sample_read(sample_read), .pattern(pattern),
      .sample_data(sample_data));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic conclude();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Record reads and the overlay in force; cut a hang short
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (sample_read) begin
         last_addr <= sample_addr;
         last_pat <= pattern;
         reads <= reads + 1;
         if (!seen)
            first_addr <= sample_addr;
         seen <= 1'b1;
      end
      if (cyc == 5000) begin
         fail_count++;
         conclude();
      end
   end
   // Every converter word must be the memory word of the last read
   always @(negedge clock)
      if (dac_valid === 1'b1)
         check(dac_data, exp_word);
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wstep(input logic [11:0] i, input logic [11:0] n,
      input logic [15:0] s, input logic [19:0] l, input logic [1:0] c);
      tick(1);
      step_wr_en = 1;
      step_wr_index = i;
      step_wr_next = n;
      step_wr_segment = s;
      step_wr_loops = l;
      step_wr_command = c;
      tick(1);
      step_wr_en = 0;
   endtask
   task automatic wseg(input logic [15:0] i, input logic [29:0] len);
      tick(1);
      seg_wr_en = 1;
      seg_wr_index = i;
      seg_wr_length = len;
      tick(1);
      seg_wr_en = 0;
   endtask
   task automatic launch();
      tick(1);
      seen = 0;
      reads = 0;
      start = 1;
      tick(1);
      start = 0;
   endtask
   task automatic wait_done(input int lim);
      for (int k = 0; k < lim && done !== 1'b1; k++)
         tick(1);
   endtask
   // Two-step walk reaching the last table slot, overlay mid-run
   task automatic t_walk();
      wseg(16'h1, 30'h28);
      wseg(16'h0, 30'h20);
      wstep(12'h0, 12'hfff, 16'h1, 20'h3, SRPC_CMD_NEXT);
      wstep(12'hfff, 12'h0, 16'h0, 20'h2, SRPC_CMD_END);
      launch();
      tick(60);
      check(current_step, 12'h0);
      pattern = 16'h5a5a;
      tick(80);
      check(current_step, 12'hfff);
      wait_done(400);
      tick(2);
      check(done, 1);
      check(reads, 32'hb8);
      check(first_addr, 29'h10000000);
   endtask
   // Trigger loop whose follower is rewritten while it loops
   task automatic t_trig();
      int k;
      wstep(12'h0, 12'h1, 16'h0, 20'h1, SRPC_CMD_UNTIL_TRIG);
      wstep(12'h1, 12'h0, 16'h1, 20'h1, SRPC_CMD_END);
      launch();
      wstep(12'h1, 12'h0, 16'h1, 20'h2, SRPC_CMD_END);
      // Delayed edge lands exactly on the fourth iteration's last sample
      tick(104);
      check(done, 0);
      ext_trigger = 1;
      tick(2);
      ext_trigger = 0;
      for (k = 2; k < 300 && done !== 1'b1; k++)
         tick(1);
      check(k, 104);
   endtask
   // Trigger one clock later misses that boundary: one more iteration
   task automatic t_trig_late();
      int k;
      launch();
      tick(107);
      ext_trigger = 1;
      tick(2);
      ext_trigger = 0;
      for (k = 2; k < 300 && done !== 1'b1; k++)
         tick(1);
      check(k, 135);
   endtask
   // Eight channels, 64Ki segments: an over-long entry is clipped to 1024
   task automatic t_cap();
      active_channels = 4'h8;
      segment_count = 17'h10000;
      wseg(16'h1, 30'h800);
      wstep(12'h0, 12'h0, 16'h1, 20'h1, SRPC_CMD_END);
      launch();
      wait_done(1100);
      tick(2);
      check(done, 1);
      check(reads, 32'h400);
      check(first_addr, 29'h400);
   endtask
   // Stop mid-step, then a fresh start must replay again
   task automatic t_stop();
      launch();
      tick(10);
      stop = 1;
      tick(1);
      stop = 0;
      check(running, 0);
      launch();
      tick(2);
      check(running, 1);
   endtask
   initial begin
      tick(16);
      reset_n = 1;
      t_walk();
      t_trig();
      t_trig_late();
      t_cap();
      t_stop();
      conclude();
   end
endmodule // srpc_main_tb_top

// ==== testbench/srpc_mem_model.sv ====
/*
 Sample memory model on the far side of the replay path.
 Assumes the controller takes the word at the edge ending the read cycle.
*/
`timescale 1ns/100ps
module srpc_mem_model (
   input wire logic [28:0] sample_addr,
   input wire logic sample_read,
   input wire logic [15:0] pattern,
   output logic [15:0] sample_data
);
   logic [15:0] word;
   // Content follows the address; host overlay changes it live
   assign word = sample_addr[15:0] ^ sample_addr[28:13] ^ pattern;
   // Unread cycles show the inverse so a stale capture is caught
   assign sample_data = sample_read ? word : ~word;
endmodule // srpc_mem_model
